// *** verification/qbt_agent_model.sv ***
// Another open-collector agent on the lines, prompt or one cycle late
`timescale 1ns/1ps
module qbt_agent_model (
  // Clock
  input wire logic sysClk,
  // Pull request and pace
  input wire logic slow,
  input wire logic [3:0] pullReq,
  // Pull-down enables
  output logic [3:0] agentOe
);
  logic [3:0] lateReq_reg;
  always_ff @(posedge sysClk)
    lateReq_reg <= pullReq;
  // Only ever pulls low or lets go, never drives high
  assign agentOe = slow ? lateReq_reg : pullReq;
endmodule

// *** verification/qbt_transceiver_props.sv ***
// Concurrent checks on the transceiver pins
`timescale 1ns/1ps
module qbt_transceiver_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control and data pins
  input wire logic driver_register_clock,
  input wire logic bus_drive_enable_n,
  input wire logic receive_latch_enable_n,
  input wire logic field_select,
  input wire logic [qbt_pkg::LANES-1:0] first_word_in,
  input wire logic [qbt_pkg::LANES-1:0] second_word_in,
  // Lines, receiver and parity
  input wire logic [qbt_pkg::LANES-1:0] shared_line_n_in,
  input wire logic [qbt_pkg::LANES-1:0] shared_line_n_out,
  input wire logic [qbt_pkg::LANES-1:0] shared_line_n_oe,
  input wire logic [qbt_pkg::LANES-1:0] receiver_out,
  input wire logic odd_parity_out
);
  logic [qbt_pkg::LANES-1:0] selWord;
  assign selWord = field_select ? second_word_in : first_word_in;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence loadRise;
    $rose(driver_register_clock) && !bus_drive_enable_n;
  endsequence
  sequence driveSteady;
    (!bus_drive_enable_n && !$rose(driver_register_clock))[*4];
  endsequence
  load_drive_a: assert property (loadRise ##1 driveSteady
    |-> shared_line_n_oe == $past(selWord, 5)) else $error("load not driven");
  reg_hold_a: assert property ((!$rose(driver_register_clock)
    && !bus_drive_enable_n)[*6] |-> $stable(shared_line_n_oe))
    else $error("register moved without edge");
  oe_release_a: assert property (bus_drive_enable_n[*4]
    |-> shared_line_n_oe == qbt_pkg::WORD_ZERO) else $error("not released");
  out_low_a: assert property (shared_line_n_out == qbt_pkg::LINE_PULL_LEVEL)
    else $error("line driven high");
  rx_follow_a: assert property ((!receive_latch_enable_n
    && $stable(shared_line_n_in))[*4] |-> receiver_out == ~shared_line_n_in)
    else $error("receiver not following");
  rx_hold_a: assert property (receive_latch_enable_n[*5]
    |-> $stable(receiver_out)) else $error("closed latch changed");
  par_gen_a: assert property ((!bus_drive_enable_n && $stable(
    {field_select, first_word_in, second_word_in}))[*5]
    |-> odd_parity_out == ~^selWord) else $error("generated parity");
  par_check_a: assert property ((bus_drive_enable_n
    && $stable(receiver_out))[*5] |-> odd_parity_out == ~^receiver_out)
    else $error("checked parity");
endmodule
bind qbt_transceiver qbt_transceiver_props PROPS (.*);

// *** verification/qbt_transceiver_test.sv ***
// Self-checking bench for the quad bus transceiver
`timescale 1ns/1ps
module qbt_transceiver_test;
  logic sysClk = 1'h0, rst_n = 1'h0, drvClk = 1'h0, driveEn_n = 1'h1;
  logic latchEn_n = 1'h0, fieldSel = 1'h0, slowAgent = 1'h1, parity;
  logic [3:0] wordA = 4'h0, wordB = 4'h0, agentReq = 4'h0;
  logic [3:0] agentOe, dutOe, lineN, rxOut;
  int n_mismatch = 0, comparisons = 0, cycles = 0;
  // Pull-up: a lane reads high unless some agent pulls it low
  assign lineN = ~(dutOe | agentOe);
  always #50 sysClk = ~sysClk;
  qbt_transceiver DUT (.sys_clk(sysClk), .rst_n(rst_n),
    .driver_register_clock(drvClk), .bus_drive_enable_n(driveEn_n),
    .receive_latch_enable_n(latchEn_n), .field_select(fieldSel),
    .first_word_in(wordA), .second_word_in(wordB),
    .shared_line_n_in(lineN), .shared_line_n_out(),
    .shared_line_n_oe(dutOe), .receiver_out(rxOut), .odd_parity_out(parity));
  qbt_agent_model AGENT (.sysClk(sysClk), .slow(slowAgent),
    .pullReq(agentReq), .agentOe(agentOe));
  task automatic complete_run();
    if (n_mismatch == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sysClk);
  endtask
  task automatic check(input logic [4:0] got, input logic [4:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Synchroniser needs data steady around the rise
  task automatic load_word(input logic sel, input logic [3:0] a, b);
    fieldSel <= sel;
    wordA <= a;
    wordB <= b;
    wait_cyc(3);
    drvClk <= 1'h1;
    wait_cyc(3);
    drvClk <= 1'h0;
    wait_cyc(3);
  endtask
  task automatic drive_and_echo();
    logic [3:0] w;
    for (int s = 0; s < 2; s++)
    begin
      w = s ? 4'h3 : 4'hB;
      load_word(s[0], 4'hB, 4'h3);
      driveEn_n <= 1'h0;
      wait_cyc(9);
      check({1'h0, dutOe}, {1'h0, w});
      check({parity, rxOut}, {~^w, w});
    end
  endtask
  task automatic hold_register();
    wordA <= 4'h5;
    fieldSel <= 1'h0;
    wait_cyc(6);
    check({parity, dutOe}, 5'h13);
  endtask
  task automatic release_and_latch();
    driveEn_n <= 1'h1;
    agentReq <= 4'h7;
    wait_cyc(9);
    check({1'h0, dutOe}, 5'h00);
    check({parity, rxOut}, 5'h07);
    latchEn_n <= 1'h1;
    wait_cyc(4);
    agentReq <= 4'h9;
    slowAgent <= 1'h0;
    wait_cyc(8);
    check({parity, rxOut}, 5'h07);
    latchEn_n <= 1'h0;
    wait_cyc(8);
    check({parity, rxOut}, 5'h19);
  endtask
  task automatic wired_or();
    load_word(1'h0, 4'h1, 4'h0);
    driveEn_n <= 1'h0;
    agentReq <= 4'h4;
    wait_cyc(9);
    check({parity, rxOut}, 5'h05);
  endtask
  always @(posedge sysClk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_mismatch++;
      complete_run();
    end
  end
  initial
  begin
    wait_cyc(4);
    rst_n <= 1'h1;
    wait_cyc(1);
    drive_and_echo();
    hold_register();
    release_and_latch();
    wired_or();
    complete_run();
  end
endmodule

// *** verilog/qbt_pkg.sv ***
// Constants and carrier types for the quad bus transceiver with parity
// Operation
// - Four edge-triggered transmit flops hold the word, each fed by its own two-way multiplexer.
// - One shared field select picks the first word when low and the second word when high.
// - The transmit register captures the selected word only on a rising edge of its clock.
// - While the driver register clock stays low or high the transmit register holds its value.
// - A driven lane carries the inverse of its stored bit, so a stored one pulls the line low.
// - With the bus drive enable high all drivers release; with it low they drive the register.
// - Every shared line is a wired-OR node that any agent may only pull low or release.
// - The receive path inverts the line, so transmitted data comes back non-inverted.
// - While the receive latch enable is low the receiver outputs follow the inverted lines.
// - When the receive latch enable goes high the latches close and hold their values.
// - One odd-parity output covers four bits, generating or checking by the drive enable.
// - With the drive enable low the parity covers the selected word at the register inputs.
// - With the drive enable high the parity covers the four receive latch outputs.
package qbt_pkg;

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int LANES = 4;
  localparam logic [LANES-1:0] WORD_ZERO = 4'h0;
  localparam logic BIT_ZERO = 1'h0;
  localparam logic BIT_ONE = 1'h1;
  // An open-collector driver only ever pulls low
  localparam logic [LANES-1:0] LINE_PULL_LEVEL = 4'h0;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic fieldSelect;
    logic [LANES-1:0] firstWord;
    logic [LANES-1:0] secondWord;
  } qbt_tx_word_type;

  typedef struct packed {
    logic driverRegisterClock;
    logic busDriveEnable_n;
    logic receiveLatchEnable_n;
  } qbt_ctrl_type;

  localparam int TX_WORD_W = $bits(qbt_tx_word_type);
  localparam int CTRL_W = $bits(qbt_ctrl_type);

endpackage

// *** verilog/qbt_sync.sv ***
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module qbt_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic sysClk,
  input wire logic rst_n,
  // Levels
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_reg;

  // First stage is read only by the second
  always_ff @(posedge sysClk)
  begin
    if (!rst_n)
    begin
      stage1_reg <= '0;
      syncOut <= '0;
    end
    else
    begin
      stage1_reg <= asyncIn;
      syncOut <= stage1_reg;
    end
  end

endmodule

// *** verilog/qbt_transceiver.sv ***
// Quad open-collector bus transceiver with odd parity
`timescale 1ns/1ps
module qbt_transceiver (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control pins
  input wire logic driver_register_clock,
  input wire logic bus_drive_enable_n,
  input wire logic receive_latch_enable_n,
  // Local data pins
  input wire logic field_select,
  input wire logic [qbt_pkg::LANES-1:0] first_word_in,
  input wire logic [qbt_pkg::LANES-1:0] second_word_in,
  // Shared open-collector lines
  input wire logic [qbt_pkg::LANES-1:0] shared_line_n_in,
  output logic [qbt_pkg::LANES-1:0] shared_line_n_out,
  output logic [qbt_pkg::LANES-1:0] shared_line_n_oe,
  // Receiver and parity
  output logic [qbt_pkg::LANES-1:0] receiver_out,
  output logic odd_parity_out
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  qbt_pkg::qbt_ctrl_type ctrlPins;
  qbt_pkg::qbt_ctrl_type ctrlSync;
  qbt_pkg::qbt_tx_word_type txPins;
  qbt_pkg::qbt_tx_word_type txSync;
  logic [qbt_pkg::LANES-1:0] lineSync;

  assign ctrlPins.driverRegisterClock = driver_register_clock;
  assign ctrlPins.busDriveEnable_n = bus_drive_enable_n;
  assign ctrlPins.receiveLatchEnable_n = receive_latch_enable_n;
  assign txPins.fieldSelect = field_select;
  assign txPins.firstWord = first_word_in;
  assign txPins.secondWord = second_word_in;

  // Data and select pass the same depth as the clock, so setup holds
  qbt_sync #(.WIDTH(qbt_pkg::CTRL_W)) ctrlSyncInst (
    .sysClk(sys_clk),
    .rst_n(rst_n),
    .asyncIn(ctrlPins),
    .syncOut(ctrlSync)
  );

  qbt_sync #(.WIDTH(qbt_pkg::TX_WORD_W)) txSyncInst (
    .sysClk(sys_clk),
    .rst_n(rst_n),
    .asyncIn(txPins),
    .syncOut(txSync)
  );

  qbt_sync #(.WIDTH(qbt_pkg::LANES)) lineSyncInst (
    .sysClk(sys_clk),
    .rst_n(rst_n),
    .asyncIn(shared_line_n_in),
    .syncOut(lineSync)
  );

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [qbt_pkg::LANES-1:0] selectWord(
    input qbt_pkg::qbt_tx_word_type w
  );
    selectWord = w.fieldSelect ? w.secondWord : w.firstWord;
  endfunction

  // High on an even count of ones
  function automatic logic oddParity(input logic [qbt_pkg::LANES-1:0] d);
    oddParity = ~(^d);
  endfunction

  // ----------------------------------------------------------------
  // Transmit register
  // ----------------------------------------------------------------
  logic clkPrev_reg;
  logic [qbt_pkg::LANES-1:0] txWordSel;
  logic captureEdge;
  logic [qbt_pkg::LANES-1:0] txData_reg;
  logic [qbt_pkg::LANES-1:0] txData_next;

  assign txWordSel = selectWord(txSync);
  // Edge seen in the same cycle as the synchronised rise
  assign captureEdge = ctrlSync.driverRegisterClock & ~clkPrev_reg;
  assign txData_next = captureEdge ? txWordSel : txData_reg;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      clkPrev_reg <= qbt_pkg::BIT_ONE;
    else
      clkPrev_reg <= ctrlSync.driverRegisterClock;
  end

  // No reset: contents are whatever the first capture leaves
  always_ff @(posedge sys_clk)
  begin
    txData_reg <= txData_next;
  end

  // ----------------------------------------------------------------
  // Open-collector drivers
  // ----------------------------------------------------------------
  logic [qbt_pkg::LANES-1:0] lineOe_next;
  logic [qbt_pkg::LANES-1:0] lineOe_reg;
  logic [qbt_pkg::LANES-1:0] lineOut_reg;

  genvar lane;
  generate
    for (lane = 0; lane < qbt_pkg::LANES; lane++)
    begin : gDrv
      // A stored one pulls low; a zero leaves the line released
      assign lineOe_next[lane] =
        ~ctrlSync.busDriveEnable_n & txData_reg[lane];
    end
  endgenerate

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      lineOe_reg <= qbt_pkg::WORD_ZERO;
      lineOut_reg <= qbt_pkg::LINE_PULL_LEVEL;
    end
    else
    begin
      lineOe_reg <= lineOe_next;
      lineOut_reg <= qbt_pkg::LINE_PULL_LEVEL;
    end
  end

  assign shared_line_n_oe = lineOe_reg;
  assign shared_line_n_out = lineOut_reg;

  // ----------------------------------------------------------------
  // Receive latches
  // ----------------------------------------------------------------
  logic [qbt_pkg::LANES-1:0] rxData_reg;
  logic [qbt_pkg::LANES-1:0] rxData_next;
  logic latchOpen;

  assign latchOpen = ~ctrlSync.receiveLatchEnable_n;
  assign rxData_next = latchOpen ? ~lineSync : rxData_reg;

  // Reset only so the output pins show a known value
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      rxData_reg <= qbt_pkg::WORD_ZERO;
    else
      rxData_reg <= rxData_next;
  end

  assign receiver_out = rxData_reg;

  // ----------------------------------------------------------------
  // Parity generate / check
  // ----------------------------------------------------------------
  logic [qbt_pkg::LANES-1:0] paritySource;
  logic parity_reg;
  logic parity_next;

  // Check mode uses the latch outputs as they stand on the pins
  assign paritySource = ctrlSync.busDriveEnable_n ?
    rxData_reg : txWordSel;
  assign parity_next = oddParity(paritySource);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      parity_reg <= qbt_pkg::BIT_ZERO;
    else
      parity_reg <= parity_next;
  end

  assign odd_parity_out = parity_reg;

endmodule
